// [pkg/sfr_bank1_consts.vh]
`ifndef SFR_BANK1_CONSTS_VH
`define SFR_BANK1_CONSTS_VH
// Bank-one offsets
`define ADDR_INDIRECT_ACCESS_PORT 8'h80
`define ADDR_OPTION_CONFIG 8'h81
`define ADDR_PROG_COUNTER_LOW 8'h82
`define ADDR_CORE_STATUS 8'h83
`define ADDR_INDIRECT_POINTER 8'h84
`define ADDR_PORTA_DIRECTION 8'h85
`define ADDR_PORTB_DIRECTION 8'h86
`define ADDR_PORTC_DIRECTION 8'h87
`define ADDR_PC_HIGH_LATCH 8'h8A
`define ADDR_INTERRUPT_CONTROL 8'h8B
`define ADDR_PERIPHERAL_IRQ_ENABLE 8'h8C
`define ADDR_POWER_RESET_FLAGS 8'h8E
`define ADDR_TIMER2_PERIOD 8'h92
`define ADDR_SERIAL_SLAVE_ADDRESS 8'h93
`define ADDR_SERIAL_PORT_STATE 8'h94
`define ADDR_ANALOG_PORT_CONFIG 8'h9F
// Bank-zero port data offsets
`define ADDR_PORTA_DATA 8'h05
`define ADDR_PORTB_DATA 8'h06
`define ADDR_PORTC_DATA 8'h07
// Core status bit positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_SLEEP 3
`define ST_WDOG 4
`define ST_BANK_LOW 5
`define ST_BANK_HIGH 6
`define ST_IND_BANK 7
// Reset values and masks
`define RST_OPTION_CONFIG 8'hFF
`define RST_DIRECTION 8'hFF
`define RST_PORTA_DIRECTION 8'h3F
`define MASK_PORTA 8'h3F
`define MASK_PC_HIGH 8'h1F
`define MASK_PIE 8'h4F
`define MASK_ANALOG 8'h07
`define RST_TIMER2_PERIOD 8'hFF
`define RST_ZERO8 8'h00
`endif

// [hw/sfr_bank1.v]
`include "sfr_bank1_consts.vh"

// Summary of operation
// - Indirect, pc low, status, pointer, pc latch, interrupt control reachable from both banks.
// - Upper pc bits only via 5-bit latch, loaded into pc on low-byte write.
// - Power-on/brown-out events and rst both load status bits 7:3 with 00011; only rst clears bits 2:0.
// - rst sets all implemented port direction bits, making pins inputs; POR/BOR events leave direction unchanged.
// - Port A direction has six bits, upper two unimplemented, reset all ones.
// - Unimplemented addresses and bits read zero; writes ignored.
// - Status holds ALU flags, reset-cause flags and bank select bits.
// - Any instruction may write status like any file register.
// - Flag-updating instruction writing status: data write to Z, DC, C suppressed.
// - Watchdog and sleep flags ignore writes; only device logic changes them.
// - File clear of status clears upper three bits and sets zero flag, unless flags_update loads Z from the ALU.
// - Subtraction: carry is inverted borrow, nibble flag inverted nibble borrow.
// - Pointer holds eight-bit address; indirect port acts on pointed location.
// - Bank-zero port writes drive the latch; reads return pin levels.
module sfr_bank1 #(
  parameter HAS_ANALOG = 1
)
(
  input wire clk,
  input wire rst,
  input wire por_event,
  input wire bor_event,
  input wire wdt_event,
  input wire sleep_event,
  input wire clrwdt_event,
  input wire [6:0] dir_addr,
  input wire indirect_sel,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire file_clear_op,
  input wire flags_update,
  input wire flag_zero,
  input wire flag_nibble_carry,
  input wire flag_carry,
  input wire [7:0] mem_rd_data,
  input wire [7:0] porta_pins,
  input wire [7:0] portb_pins,
  input wire [7:0] portc_pins,
  output reg [7:0] rd_data,
  output reg [7:0] mem_addr,
  output reg mem_wr,
  output reg [7:0] mem_wr_data,
  output reg [12:0] pc_q,
  output reg [7:0] porta_direction,
  output reg [7:0] portb_direction,
  output reg [7:0] portc_direction,
  output reg [7:0] porta_latch,
  output reg [7:0] portb_latch,
  output reg [7:0] portc_latch,
  output reg [7:0] core_status,
  output reg [7:0] option_config,
  output reg [7:0] interrupt_control,
  output reg [7:0] peripheral_irq_enable,
  output reg [7:0] timer2_period,
  output reg [7:0] serial_slave_address,
  output reg [7:0] analog_port_config
);

  reg [7:0] indirect_pointer;
  reg [7:0] pc_high_latch;
  reg [7:0] power_reset_flags;
  reg [7:0] serial_port_state;
  reg [7:0] porta_sync1;
  reg [7:0] porta_sync2;
  reg [7:0] portb_sync1;
  reg [7:0] portb_sync2;
  reg [7:0] portc_sync1;
  reg [7:0] portc_sync2;
  reg por_sync1;
  reg por_sync2;
  reg bor_sync1;
  reg bor_sync2;
  reg [7:0] eff_addr;
  reg [7:0] rd_value;

  // Folds mirrored bank-one core registers onto their bank-zero view
  function [7:0] fold_addr;
    input [7:0] a;
    begin
      case (a)
        `ADDR_INDIRECT_ACCESS_PORT, `ADDR_PROG_COUNTER_LOW, `ADDR_CORE_STATUS,
        `ADDR_INDIRECT_POINTER, `ADDR_PC_HIGH_LATCH, `ADDR_INTERRUPT_CONTROL:
          fold_addr = {1'b0, a[6:0]};
        default:
          fold_addr = a;
      endcase
    end
  endfunction

  wire [7:0] direct_addr = {core_status[`ST_BANK_LOW], dir_addr};
  wire [7:0] raw_addr = indirect_sel ? indirect_pointer : direct_addr;
  wire [7:0] reg_addr = fold_addr(raw_addr);
  wire ind_access = (reg_addr == 8'h00);
  wire wr_hit = wr_en && !ind_access;

  always @*
  begin
    eff_addr = reg_addr;
    rd_value = 8'h00;
    case (eff_addr)
      8'h02: rd_value = pc_q[7:0];
      8'h03: rd_value = core_status;
      8'h04: rd_value = indirect_pointer;
      8'h0A: rd_value = pc_high_latch & `MASK_PC_HIGH;
      8'h0B: rd_value = interrupt_control;
      `ADDR_PORTA_DATA: rd_value = porta_sync2 & `MASK_PORTA;
      `ADDR_PORTB_DATA: rd_value = portb_sync2;
      `ADDR_PORTC_DATA: rd_value = portc_sync2;
      `ADDR_OPTION_CONFIG: rd_value = option_config;
      `ADDR_PORTA_DIRECTION: rd_value = porta_direction & `MASK_PORTA;
      `ADDR_PORTB_DIRECTION: rd_value = portb_direction;
      `ADDR_PORTC_DIRECTION: rd_value = portc_direction;
      `ADDR_PERIPHERAL_IRQ_ENABLE: rd_value = peripheral_irq_enable;
      `ADDR_POWER_RESET_FLAGS: rd_value = power_reset_flags;
      `ADDR_TIMER2_PERIOD: rd_value = timer2_period;
      `ADDR_SERIAL_SLAVE_ADDRESS: rd_value = serial_slave_address;
      `ADDR_SERIAL_PORT_STATE: rd_value = serial_port_state;
      `ADDR_ANALOG_PORT_CONFIG: rd_value = analog_port_config;
      default: rd_value = 8'h00;
    endcase
  end

  // Pin and reset-cause synchronisers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      porta_sync1 <= 8'h00;
      porta_sync2 <= 8'h00;
      portb_sync1 <= 8'h00;
      portb_sync2 <= 8'h00;
      portc_sync1 <= 8'h00;
      portc_sync2 <= 8'h00;
      por_sync1 <= 1'b0;
      por_sync2 <= 1'b0;
      bor_sync1 <= 1'b0;
      bor_sync2 <= 1'b0;
    end
    else
    begin
      porta_sync1 <= porta_pins;
      porta_sync2 <= porta_sync1;
      portb_sync1 <= portb_pins;
      portb_sync2 <= portb_sync1;
      portc_sync1 <= portc_pins;
      portc_sync2 <= portc_sync1;
      por_sync1 <= por_event;
      por_sync2 <= por_sync1;
      bor_sync1 <= bor_event;
      bor_sync2 <= bor_sync1;
    end
  end

  // Read path and indirect memory access
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
      mem_addr <= 8'h00;
      mem_wr <= 1'b0;
      mem_wr_data <= 8'h00;
    end
    else
    begin
      mem_addr <= indirect_pointer;
      mem_wr <= wr_en && ind_access;
      mem_wr_data <= wr_data;
      if (rd_en)
        rd_data <= ind_access ? mem_rd_data : rd_value;
    end
  end

  // Register file; rst is the other-reset class, POR/BOR adjusts status
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pc_q <= 13'h0000;
      pc_high_latch <= `RST_ZERO8;
      core_status <= 8'h18;
      indirect_pointer <= `RST_ZERO8;
      option_config <= `RST_OPTION_CONFIG;
      porta_direction <= `RST_PORTA_DIRECTION;
      portb_direction <= `RST_DIRECTION;
      portc_direction <= `RST_DIRECTION;
      porta_latch <= 8'h00;
      portb_latch <= 8'h00;
      portc_latch <= 8'h00;
      interrupt_control <= `RST_ZERO8;
      peripheral_irq_enable <= `RST_ZERO8;
      power_reset_flags <= 8'h03;
      timer2_period <= `RST_TIMER2_PERIOD;
      serial_slave_address <= `RST_ZERO8;
      serial_port_state <= `RST_ZERO8;
      analog_port_config <= `RST_ZERO8;
    end
    else
    begin
      if (por_sync2 || bor_sync2)
      begin
        core_status[7:3] <= 5'b00011;
        if (por_sync2)
          power_reset_flags[1] <= 1'b0;
        if (bor_sync2)
          power_reset_flags[0] <= 1'b0;
      end
      else
      begin
        if (wdt_event)
          core_status[`ST_WDOG] <= 1'b0;
        else if (clrwdt_event)
          core_status[`ST_WDOG] <= 1'b1;
        if (sleep_event)
          core_status[`ST_SLEEP] <= 1'b0;
        else if (clrwdt_event)
          core_status[`ST_SLEEP] <= 1'b1;
        if (wr_hit && reg_addr == 8'h03)
        begin
          if (file_clear_op)
            core_status[7:5] <= 3'b000;
          else
            core_status[7:5] <= wr_data[7:5];
          if (!flags_update && !file_clear_op)
            core_status[2:0] <= wr_data[2:0];
        end
        if (flags_update)
        begin
          core_status[`ST_ZERO] <= flag_zero;
          core_status[`ST_NIBBLE] <= flag_nibble_carry;
          core_status[`ST_CARRY] <= flag_carry;
        end
        if (wr_hit && reg_addr == 8'h03 && file_clear_op && !flags_update)
          core_status[`ST_ZERO] <= 1'b1;
        if (wr_hit)
        begin
          case (reg_addr)
            8'h02: pc_q <= {pc_high_latch[4:0], wr_data};
            8'h04: indirect_pointer <= wr_data;
            8'h0A: pc_high_latch <= wr_data & `MASK_PC_HIGH;
            8'h0B: interrupt_control <= wr_data;
            `ADDR_PORTA_DATA: porta_latch <= wr_data & `MASK_PORTA;
            `ADDR_PORTB_DATA: portb_latch <= wr_data;
            `ADDR_PORTC_DATA: portc_latch <= wr_data;
            `ADDR_OPTION_CONFIG: option_config <= wr_data;
            `ADDR_PORTA_DIRECTION: porta_direction <= wr_data & `MASK_PORTA;
            `ADDR_PORTB_DIRECTION: portb_direction <= wr_data;
            `ADDR_PORTC_DIRECTION: portc_direction <= wr_data;
            `ADDR_PERIPHERAL_IRQ_ENABLE:
              peripheral_irq_enable <= wr_data & (HAS_ANALOG ? `MASK_PIE : 8'h0F);
            `ADDR_POWER_RESET_FLAGS: power_reset_flags <= wr_data & 8'h03;
            `ADDR_TIMER2_PERIOD: timer2_period <= wr_data;
            `ADDR_SERIAL_SLAVE_ADDRESS: serial_slave_address <= wr_data;
            `ADDR_SERIAL_PORT_STATE: serial_port_state[7:6] <= wr_data[7:6];
            `ADDR_ANALOG_PORT_CONFIG:
              analog_port_config <= HAS_ANALOG ? (wr_data & `MASK_ANALOG) : 8'h00;
            default: ;
          endcase
        end
      end
    end
  end

endmodule // sfr_bank1

// [testbench/sfr_bank1_monitor.sv]
module sfr_bank1_checker (
  input wire clk,
  input wire rst,
  input wire wdt_event,
  input wire sleep_event,
  input wire clrwdt_event,
  input wire [6:0] dir_addr,
  input wire indirect_sel,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire file_clear_op,
  input wire flags_update,
  input wire flag_zero,
  input wire flag_nibble_carry,
  input wire flag_carry,
  input wire mem_wr,
  input wire [7:0] mem_wr_data,
  input wire [12:0] pc_q,
  input wire [7:0] porta_direction,
  input wire [7:0] portb_direction,
  input wire [7:0] core_status
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire st_wr = wr_en && !indirect_sel && dir_addr == 7'h03;
  wire [2:0] alu_flags = {flag_zero, flag_nibble_carry, flag_carry};
  sequence s_ind_req;
    wr_en && !indirect_sel && dir_addr == 7'h00;
  endsequence
  sequence s_mem_put;
    mem_wr && mem_wr_data == $past(wr_data);
  endsequence
  a_dir_reset: assert property ($fell(rst) |-> porta_direction == 8'h3F &&
    portb_direction == 8'hFF) else $error("direction reset value wrong");
  a_status_reset: assert property ($fell(rst) |-> core_status[7:3] == 5'h03)
    else $error("status reset value wrong");
  a_porta_unimpl: assert property (porta_direction[7:6] == 2'h0)
    else $error("port a direction upper bits set");
  a_wdog_keep: assert property ((!(wdt_event || sleep_event || clrwdt_event))[*4]
    |=> $stable(core_status[4:3])) else $error("reset-cause flags changed");
  a_wdog_clear: assert property (wdt_event && !clrwdt_event |=> !core_status[4])
    else $error("watchdog flag not cleared");
  a_flag_override: assert property (st_wr && flags_update && !file_clear_op
    |=> core_status[2:0] == $past(alu_flags)) else $error("flags not from alu");
  a_file_clear: assert property (st_wr && file_clear_op && !flags_update |=>
    core_status[7:5] == 3'h0 && core_status[2] && core_status[1:0] == $past(core_status[1:0]))
    else $error("file clear of status wrong");
  a_pc_low: assert property (wr_en && !indirect_sel && dir_addr == 7'h02
    |=> pc_q[7:0] == $past(wr_data)) else $error("pc low byte not loaded");
  a_ind_write: assert property (s_ind_req |=> s_mem_put)
    else $error("indirect write not passed to memory");
endmodule // sfr_bank1_checker

bind sfr_bank1 sfr_bank1_checker chk_u (.clk(clk), .rst(rst), .wdt_event(wdt_event),
  .sleep_event(sleep_event), .clrwdt_event(clrwdt_event), .dir_addr(dir_addr),
  .indirect_sel(indirect_sel), .wr_en(wr_en), .wr_data(wr_data), .file_clear_op(file_clear_op),
  .flags_update(flags_update), .flag_zero(flag_zero), .flag_nibble_carry(flag_nibble_carry),
  .flag_carry(flag_carry), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .pc_q(pc_q),
  .porta_direction(porta_direction), .portb_direction(portb_direction),
  .core_status(core_status));

// [testbench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic wdt_event, sleep_event, clrwdt_event, indirect_sel, wr_en, rd_en;
  logic file_clear_op, flags_update, flag_zero, flag_nibble_carry, flag_carry;
  logic por_event, bor_event;
  logic [6:0] dir_addr;
  logic [7:0] wr_data, mem_rd_data, porta_pins, portb_pins, portc_pins, d;
  wire [7:0] rd_data, portb_latch, core_status, option_config, timer2_period;
  wire [7:0] porta_direction, portb_direction;
  wire [12:0] pc_q;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [6:0] ra [10] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h0A, 7'h0B, 7'h0C, 7'h12, 7'h13, 7'h1F};
  logic [6:0] ua [3] = '{7'h08, 7'h0D, 7'h15};
  always #10 clk = ~clk;
  sfr_bank1 dut_u (.clk(clk), .rst(rst), .por_event(por_event), .bor_event(bor_event),
    .wdt_event(wdt_event), .sleep_event(sleep_event), .clrwdt_event(clrwdt_event),
    .dir_addr(dir_addr), .indirect_sel(indirect_sel), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .file_clear_op(file_clear_op), .flags_update(flags_update),
    .flag_zero(flag_zero), .flag_nibble_carry(flag_nibble_carry), .flag_carry(flag_carry),
    .mem_rd_data(mem_rd_data), .porta_pins(porta_pins), .portb_pins(portb_pins),
    .portc_pins(portc_pins), .rd_data(rd_data), .mem_addr(), .mem_wr(), .mem_wr_data(),
    .pc_q(pc_q), .porta_direction(porta_direction), .portb_direction(portb_direction),
    .portc_direction(), .porta_latch(), .portb_latch(portb_latch), .portc_latch(),
    .core_status(core_status), .option_config(option_config), .interrupt_control(),
    .peripheral_irq_enable(), .timer2_period(timer2_period), .serial_slave_address(),
    .analog_port_config());
  function logic [7:0] msk(input logic [6:0] a);
    case (a)
      7'h05: msk = 8'h3F;
      7'h0A: msk = 8'h1F;
      7'h0C: msk = 8'h4F;
      7'h1F: msk = 8'h07;
      default: msk = 8'hFF;
    endcase
  endfunction
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task acc(input logic [6:0] a, input logic [7:0] v, input logic w);
    @(posedge clk);
    dir_addr <= a;
    wr_data <= v;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 0;
    rd_en <= 0;
    @(posedge clk);
    #1;
  endtask
  task pulse(input logic [2:0] k, input logic [1:0] e);
    @(posedge clk);
    {clrwdt_event, sleep_event, wdt_event} <= k;
    @(posedge clk);
    {clrwdt_event, sleep_event, wdt_event} <= 3'h0;
    @(posedge clk);
    #1;
    chk("reset cause flags", core_status[4:3], e);
  endtask
  task cause(input logic p, input logic b, input logic [7:0] e);
    @(posedge clk);
    {por_event, bor_event} <= {p, b};
    @(posedge clk);
    {por_event, bor_event} <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("cause status", core_status[7:3], 5'h03);
    acc(7'h03, 8'h20, 1);
    acc(7'h0E, 8'h00, 0);
    chk("reset flags", rd_data, e);
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    {wdt_event, sleep_event, clrwdt_event, indirect_sel, wr_en, rd_en} = '0;
    {file_clear_op, flags_update, flag_zero, flag_nibble_carry, flag_carry} = '0;
    {dir_addr, wr_data, porta_pins, portc_pins} = '0;
    {por_event, bor_event} = '0;
    void'($urandom(5182));
    mem_rd_data = $urandom;
    portb_pins = $urandom;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("status", core_status, 8'h18);
    chk("dir a", porta_direction, 8'h3F);
    chk("dir b", portb_direction, 8'hFF);
    chk("option", option_config, 8'hFF);
    chk("period", timer2_period, 8'hFF);
    $display("test reset values done");
    acc(7'h03, 8'h20, 1);
    chk("bank select", core_status, 8'h38);
    foreach (ra[i])
    begin
      d = $urandom;
      acc(ra[i], d, 1);
      acc(ra[i], 8'h00, 0);
      chk("readback", rd_data, d & msk(ra[i]));
    end
    foreach (ua[i])
    begin
      acc(ua[i], 8'hFF, 1);
      acc(ua[i], 8'h00, 0);
      chk("unmapped", rd_data, 8'h00);
    end
    $display("test register access done");
    acc(7'h0A, 8'hF5, 1);
    acc(7'h02, 8'hA5, 1);
    chk("pc", pc_q, 13'h15A5);
    {flags_update, flag_zero, flag_nibble_carry, flag_carry} <= 4'hD;
    acc(7'h03, 8'h22, 1);
    chk("alu flags", core_status, 8'h3D);
    flags_update <= 0;
    file_clear_op <= 1;
    acc(7'h03, 8'hFF, 1);
    chk("file clear", core_status, 8'h1D);
    file_clear_op <= 0;
    acc(7'h0A, 8'h00, 0);
    chk("mirror", rd_data, 8'h15);
    $display("test status and pc done");
    d = $urandom;
    acc(7'h06, d, 1);
    chk("latch", portb_latch, d);
    acc(7'h06, 8'h00, 0);
    chk("pins", rd_data, portb_pins);
    acc(7'h04, 8'h55, 1);
    acc(7'h00, 8'hC3, 1);
    acc(7'h00, 8'h00, 0);
    chk("indirect read", rd_data, mem_rd_data);
    acc(7'h04, 8'h03, 1);
    indirect_sel <= 1;
    acc(7'h00, 8'h00, 0);
    chk("pointer select", rd_data, 8'h1D);
    indirect_sel <= 0;
    pulse(3'h1, 2'h1);
    pulse(3'h2, 2'h0);
    pulse(3'h4, 2'h3);
    $display("test ports and flags done");
    cause(1'b1, 1'b0, 8'h01);
    cause(1'b0, 1'b1, 8'h00);
    $display("test reset causes done");
    acc(7'h03, 8'h20, 1);
    acc(7'h06, 8'h00, 1);
    chk("dir b written", portb_direction, 8'h00);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("dir b reset", portb_direction, 8'hFF);
    chk("status upper", core_status[7:5], 3'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule // tb_top
